//--- verilog/swdr_pkg.sv
// shared constants and types of the supervisor watchdog reset block
package swdr_pkg;
  localparam int CNT_W = 32;
  typedef logic [CNT_W-1:0] swdr_cnt_t;

  // time base
  localparam longint CLK_NS = 4;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint NS_PER_MS = 1_000_000;

  // strapped watchdog and reset timeouts
  localparam longint WD_SHORT_NS = 3_200_000;
  localparam longint WD_LONG_NS = 1_600_000_000;
  localparam longint RST_SHORT_NS = 400_000;
  localparam longint RST_LONG_NS = 200_000_000;

  // timing-element scaled timeouts
  localparam longint WD_CAP_PF = 47_000;
  localparam longint WD_PF_PER_S = 13_800;
  localparam longint RST_CAP_PF = 2_200;
  localparam longint RST_PF_PER_MS = 110;
  localparam longint WD_ADJ_NS = WD_CAP_PF * NS_PER_S / WD_PF_PER_S;
  localparam longint RST_ADJ_NS = RST_CAP_PF * NS_PER_MS / RST_PF_PER_MS;

  localparam swdr_cnt_t WD_SHORT_CYC = swdr_cnt_t'(WD_SHORT_NS / CLK_NS);
  localparam swdr_cnt_t WD_LONG_CYC = swdr_cnt_t'(WD_LONG_NS / CLK_NS);
  localparam swdr_cnt_t WD_ADJ_CYC = swdr_cnt_t'(WD_ADJ_NS / CLK_NS);
  localparam swdr_cnt_t RST_SHORT_CYC = swdr_cnt_t'(RST_SHORT_NS / CLK_NS);
  localparam swdr_cnt_t RST_LONG_CYC = swdr_cnt_t'(RST_LONG_NS / CLK_NS);
  localparam swdr_cnt_t RST_ADJ_CYC = swdr_cnt_t'(RST_ADJ_NS / CLK_NS);
  localparam swdr_cnt_t WD_LOWER_CYC = swdr_cnt_t'(WD_SHORT_NS / CLK_NS / 8);

  // four-way strap codes: ground, open, supply, capacitor
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_VCC = 2'h2;
  localparam logic [1:0] STRAP_CAP = 2'h3;

  // register byte offsets, control field and transfer-type constants
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAUSE = 8'h08;
  localparam logic [7:0] OFS_WDCNT = 8'h0C;
  localparam int CTRL_WIN_BIT = 0;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  typedef enum logic [1:0] {ST_HOLD, ST_TIMEOUT, ST_RUN} swdr_state_e;

  // pin inputs crossing into hclk
  typedef struct packed {
    logic kick;
    logic button;
    logic supply;
    logic lockout_ok;
    logic line;
    logic [1:0] wd_strap;
    logic [1:0] rst_strap;
  } swdr_pins_s;

  typedef struct packed {
    logic manual;
    logic early;
    logic timeout;
    logic supply;
  } swdr_cause_s;

  typedef struct packed {
    logic line_high;
    logic wd_running;
    logic rst_asserted;
  } swdr_status_s;
endpackage : swdr_pkg

//--- verilog/swdr_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module swdr_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule : swdr_sync

//--- verilog/swdr_timer.sv
// up-counting timeout timer with clear and expiry flag
`timescale 1ns/1ns
module swdr_timer #(
  parameter int W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count_ff,
  output logic expired
);
  // expiry on the last count: the period spans exactly limit cycles
  assign expired = run && (count_ff == limit - W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= '0;
    end else if (clr) begin
      count_ff <= '0;
    end else if (run && !expired) begin
      count_ff <= count_ff + W'(1);
    end
  end
endmodule : swdr_timer

//--- verilog/swdr_core.sv
// supervisor reset and watchdog core with its AHB-Lite register slave
`timescale 1ns/1ns
module swdr_core #(
  parameter swdr_pkg::swdr_cnt_t WD_SHORT_CNT = swdr_pkg::WD_SHORT_CYC,
  parameter swdr_pkg::swdr_cnt_t WD_LONG_CNT = swdr_pkg::WD_LONG_CYC,
  parameter swdr_pkg::swdr_cnt_t WD_ADJ_CNT = swdr_pkg::WD_ADJ_CYC,
  parameter swdr_pkg::swdr_cnt_t WD_LOWER_CNT = swdr_pkg::WD_LOWER_CYC,
  parameter swdr_pkg::swdr_cnt_t RST_SHORT_CNT = swdr_pkg::RST_SHORT_CYC,
  parameter swdr_pkg::swdr_cnt_t RST_LONG_CNT = swdr_pkg::RST_LONG_CYC,
  parameter swdr_pkg::swdr_cnt_t RST_ADJ_CNT = swdr_pkg::RST_ADJ_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic kick_input,
  input wire logic push_button_reset_in,
  input wire logic monitored_supply_in,
  input wire logic supply_lockout_ok,
  input wire logic [1:0] wd_period_strap,
  input wire logic [1:0] reset_period_strap,
  input wire logic rst_n_in,
  output logic rst_n_out,
  output logic rst_n_oe
);
  import swdr_pkg::*;

  swdr_pins_s pins_raw;
  swdr_pins_s pins_s;
  swdr_state_e state_ff;
  swdr_state_e nxt_state;
  swdr_cause_s cause_ff;
  swdr_cause_s cause_set;
  swdr_status_s status;
  logic kick_q_ff;
  logic button_q_ff;
  logic [1:0] wd_strap_ff;
  logic [1:0] rst_strap_ff;
  logic win_en_ff;
  logic dph_wr_ff;
  logic [7:0] dph_addr_ff;
  logic supply_ok;
  logic kick_fall;
  logic kick_rise;
  logic button_fall;
  logic wd_on;
  logic wd_kick;
  logic wd_early;
  logic wd_fault;
  logic wd_exp;
  logic rst_exp;
  logic ahb_take;
  swdr_cnt_t wd_cnt;
  swdr_cnt_t rst_cnt;
  swdr_cnt_t wd_limit;
  swdr_cnt_t rst_limit;
  swdr_cnt_t lower_eff;

  function automatic swdr_cnt_t pick_limit(
    input logic [1:0] strap,
    input swdr_cnt_t open_v,
    input swdr_cnt_t vcc_v,
    input swdr_cnt_t cap_v
  );
    unique case (strap)
      STRAP_VCC: pick_limit = vcc_v;
      STRAP_CAP: pick_limit = cap_v;
      default: pick_limit = open_v;
    endcase
  endfunction : pick_limit

  // pins cross into hclk before any edge logic looks at them
  assign pins_raw = '{kick: kick_input, button: push_button_reset_in,
                      supply: monitored_supply_in, lockout_ok: supply_lockout_ok,
                      line: rst_n_in, wd_strap: wd_period_strap,
                      rst_strap: reset_period_strap};

  swdr_sync #(.W($bits(swdr_pins_s))) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(pins_raw),
    .dout(pins_s)
  );

  assign supply_ok = pins_s.supply && pins_s.lockout_ok;
  assign kick_fall = kick_q_ff && !pins_s.kick;
  assign kick_rise = !kick_q_ff && pins_s.kick;
  assign button_fall = button_q_ff && !pins_s.button;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_q_ff <= 1'h0;
      // same level as the synchroniser's reset, so no false press follows reset
      button_q_ff <= 1'h0;
    end else begin
      kick_q_ff <= pins_s.kick;
      button_q_ff <= pins_s.button;
    end
  end

  // straps are only re-read while the supply is out, never mid-run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_strap_ff <= STRAP_OPEN;
      rst_strap_ff <= STRAP_OPEN;
    end else if (state_ff == ST_HOLD) begin
      wd_strap_ff <= pins_s.wd_strap;
      rst_strap_ff <= pins_s.rst_strap;
    end
  end

  assign wd_on = (wd_strap_ff != STRAP_GND);
  assign wd_limit = pick_limit(wd_strap_ff, WD_SHORT_CNT, WD_LONG_CNT, WD_ADJ_CNT);
  assign rst_limit = pick_limit(rst_strap_ff, RST_SHORT_CNT, RST_LONG_CNT, RST_ADJ_CNT);
  // a lower bound at or past the upper one is pulled just below it
  assign lower_eff = (WD_LOWER_CNT < wd_limit) ? WD_LOWER_CNT : wd_limit - swdr_cnt_t'(1);

  assign wd_kick = win_en_ff ? kick_fall : (kick_fall || kick_rise);
  assign wd_early = win_en_ff && kick_fall && (wd_cnt < lower_eff);
  assign wd_fault = wd_on && (wd_early || (wd_exp && !wd_kick));

  swdr_timer #(.W(CNT_W)) u_rst_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(state_ff != ST_TIMEOUT),
    .run(state_ff == ST_TIMEOUT),
    .limit(rst_limit),
    .count_ff(rst_cnt),
    .expired(rst_exp)
  );

  swdr_timer #(.W(CNT_W)) u_wd_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr((state_ff != ST_RUN) || wd_kick || !wd_on),
    .run((state_ff == ST_RUN) && wd_on),
    .limit(wd_limit),
    .count_ff(wd_cnt),
    .expired(wd_exp)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_HOLD: begin
        if (supply_ok) begin
          nxt_state = ST_TIMEOUT;
        end
      end
      ST_TIMEOUT: begin
        if (!supply_ok) begin
          nxt_state = ST_HOLD;
        end else if (rst_exp) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!supply_ok) begin
          nxt_state = ST_HOLD;
        end else if (wd_fault || button_fall) begin
          nxt_state = ST_TIMEOUT;
        end
      end
      default: nxt_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pin only ever pulls low; the pull-up gives the high level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_n_out <= 1'h0;
      rst_n_oe <= 1'h1;
    end else begin
      rst_n_out <= 1'h0;
      rst_n_oe <= (nxt_state != ST_RUN);
    end
  end

  assign cause_set = '{manual: (state_ff == ST_RUN) && supply_ok && button_fall && !wd_fault,
                       early: (state_ff == ST_RUN) && supply_ok && wd_on && wd_early,
                       timeout: (state_ff == ST_RUN) && supply_ok && wd_fault && !wd_early,
                       supply: (state_ff != ST_HOLD) && !supply_ok};

  // register slave: zero wait states, always OKAY
  assign ahb_take = hsel && hready && (htrans & HTRANS_NONSEQ_BIT) != 2'h0;
  assign status = '{line_high: pins_s.line, wd_running: (state_ff == ST_RUN) && wd_on,
                    rst_asserted: rst_n_oe};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff <= 1'h0;
      dph_addr_ff <= 8'h00;
    end else begin
      dph_wr_ff <= ahb_take && hwrite;
      dph_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_take && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL: hrdata <= 32'(win_en_ff);
        OFS_STATUS: hrdata <= 32'(status);
        OFS_CAUSE: hrdata <= 32'(cause_ff);
        OFS_WDCNT: hrdata <= 32'(wd_cnt);
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_en_ff <= CTRL_RST;
    end else if (dph_wr_ff && dph_addr_ff == OFS_CTRL) begin
      win_en_ff <= hwdata[CTRL_WIN_BIT];
    end
  end

  // write-one-to-clear; a new event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_ff <= '0;
    end else if (dph_wr_ff && dph_addr_ff == OFS_CAUSE) begin
      cause_ff <= (cause_ff & ~swdr_cause_s'(hwdata[$bits(swdr_cause_s)-1:0])) | cause_set;
    end else begin
      cause_ff <= cause_ff | cause_set;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  pin_low_only_a: assert property (rst_n_out == 1'h0 && rst_n_oe == (state_ff != ST_RUN))
    else $error("reset pin not a pure pull-down following state");
  wd_expiry_a: assert property ((state_ff == ST_RUN) && supply_ok && wd_on && wd_exp
    && !wd_kick |=> (state_ff == ST_TIMEOUT) && rst_n_oe && (rst_cnt == '0))
    else $error("watchdog expiry did not start reset period");
  release_restart_a: assert property ((state_ff == ST_TIMEOUT) && supply_ok && rst_exp
    |=> !rst_n_oe && (wd_cnt == '0) ##1 (wd_cnt == swdr_cnt_t'(wd_on)) || !rst_n_oe == 1'h0)
    else $error("release did not restart watchdog from zero");
  wd_cleared_a: assert property ((state_ff != ST_RUN) |=> (wd_cnt == '0))
    else $error("watchdog counted while reset asserted");
  early_kick_a: assert property ((state_ff == ST_RUN) && supply_ok && wd_on && win_en_ff
    && kick_fall && (wd_cnt < lower_eff) |=> (state_ff == ST_TIMEOUT) && cause_ff.early)
    else $error("early falling kick not treated as fault");
  rise_ignored_a: assert property ((state_ff == ST_RUN) && supply_ok && wd_on && win_en_ff
    && kick_rise && !wd_exp && !button_fall |=> wd_cnt == $past(wd_cnt) + swdr_cnt_t'(1))
    else $error("rising kick edge affected windowed watchdog");
  wd_disabled_a: assert property ((state_ff == ST_RUN) && supply_ok && !wd_on
    && !button_fall |=> (state_ff == ST_RUN))
    else $error("disabled watchdog caused reset");
  button_reset_a: assert property ((state_ff == ST_RUN) && supply_ok && button_fall
    |=> (state_ff == ST_TIMEOUT) ##1 rst_n_oe)
    else $error("button press did not start reset");
  supply_loss_a: assert property (!supply_ok |=> (state_ff == ST_HOLD) && rst_n_oe
    ##1 (rst_cnt == '0))
    else $error("invalid supply did not hold reset");
  strap_pick_a: assert property ((wd_strap_ff == STRAP_VCC) && (rst_strap_ff == STRAP_VCC)
    |-> (wd_limit == WD_LONG_CNT) && (rst_limit == RST_LONG_CNT))
    else $error("strap selected wrong timeout");
endmodule : swdr_core

//--- tb/swdr_proc_model.sv
// processor-side model: toggles the kick pin while the reset line is high
`timescale 1ns/1ns
module swdr_proc_model (
  input wire logic hclk,
  input wire logic rst_line,
  input wire logic kick_en,
  input wire logic [7:0] kick_gap,
  output logic kick
);
  logic [7:0] cnt_ff;

  // kick restarts from low after every reset, so edge order is known
  always_ff @(posedge hclk) begin
    if (!rst_line || !kick_en) begin
      cnt_ff <= 8'h00;
      kick <= 1'b0;
    end else if (cnt_ff >= kick_gap - 8'h01) begin
      cnt_ff <= 8'h00;
      kick <= ~kick;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule : swdr_proc_model

//--- tb/tb.sv
// self-checking bench of the supervisor watchdog reset core
`timescale 1ns/1ns
module tb;
  import swdr_pkg::*;
  localparam int RS = 20;
  localparam int RL = 40;
  localparam int WS = 64;
  localparam int WL = 128;
  localparam int WA = 96;
  logic hclk, hresetn, hsel, hwrite, kick, btn_n, supply, lock_ok, kick_en;
  logic hreadyout, hresp, rst_n_out, rst_n_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, wd_strap, rst_strap;
  logic [2:0] hsize;
  logic [7:0] kick_gap;
  wire rst_line;
  int n_mismatch, cmp_count, wt, len;

  // external pull-up on the shared reset line
  assign rst_line = rst_n_oe ? rst_n_out : 1'b1;

  // lower bound left at its default, so the clamp below the upper count is used
  swdr_core #(.WD_SHORT_CNT(32'h0000_0040), .WD_LONG_CNT(32'h0000_0080),
    .WD_ADJ_CNT(32'h0000_0060), .RST_SHORT_CNT(32'h0000_0014),
    .RST_LONG_CNT(32'h0000_0028)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .kick_input(kick), .push_button_reset_in(btn_n), .monitored_supply_in(supply),
    .supply_lockout_ok(lock_ok), .wd_period_strap(wd_strap),
    .reset_period_strap(rst_strap), .rst_n_in(rst_line), .rst_n_out(rst_n_out),
    .rst_n_oe(rst_n_oe));

  swdr_proc_model u_proc (.hclk(hclk), .rst_line(rst_line), .kick_en(kick_en),
    .kick_gap(kick_gap), .kick(kick));

  always #2 hclk = ~hclk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  // one single word transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 1'b0, hresp);
  endtask : ahb

  task automatic cause_is(input logic [31:0] exp);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("cause", exp, rd);
    ahb(1'b1, 32'h0000_0008, 32'h0000_000F);
  endtask : cause_is

  // wt: cycles until reset pulls, len: cycles the line is held low
  // a hang here is ended by the watchdog process
  task automatic wait_pull();
    wt = 0;
    while (rst_n_oe !== 1'b1) begin
      @(negedge hclk);
      wt++;
    end
    chk("line low", 1'b0, rst_line);
  endtask : wait_pull

  task automatic hold_len();
    wait_pull();
    len = 0;
    while (rst_n_oe === 1'b1) begin
      @(negedge hclk);
      len++;
    end
  endtask : hold_len

  task automatic quiet(input string nm, input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge hclk);
      if (rst_n_oe !== 1'b0) k++;
    end
    chk(nm, 0, k);
  endtask : quiet

  task automatic t_power_up();
    supply <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk("count held", 32'h0000_0000, rd);
    hold_len();
    chk_rng("power-up hold", RS - 4, RS + 6, len);
    // line readback needs the pin synchroniser's two stages
    repeat (2) @(posedge hclk);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk("status", 32'h0000_0006, rd);
    $display("done power up");
  endtask : t_power_up

  task automatic t_expire();
    hold_len();
    chk_rng("wd wait", WS - 6, WS + 6, wt);
    chk("wd hold", RS, len);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk_rng("wd restart", 0, 8, rd);
    cause_is(32'h0000_0002);
    $display("done expire");
  endtask : t_expire

  task automatic t_window();
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    kick_gap <= 8'h01;
    kick_en <= 1'b1;
    hold_len();
    chk("early hold", RS, len);
    // slow the kicks before release, or the next early fall lands on the clear
    kick_gap <= 8'h28;
    cause_is(32'h0000_0004);
    hold_len();
    cause_is(32'h0000_0002);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
    quiet("toggle keeps alive", 300);
    $display("done window");
  endtask : t_window

  task automatic t_button();
    @(posedge hclk);
    btn_n <= 1'b0;
    repeat (4) @(posedge hclk);
    btn_n <= 1'b1;
    hold_len();
    chk_rng("button wait", 0, 6, wt);
    chk("button hold", RS, len);
    cause_is(32'h0000_0008);
    $display("done button");
  endtask : t_button

  task automatic t_supply();
    @(posedge hclk);
    rst_strap <= 2'h2;
    supply <= 1'b0;
    wait_pull();
    chk_rng("loss wait", 0, 6, wt);
    @(posedge hclk);
    supply <= 1'b1;
    repeat (10) @(posedge hclk);
    supply <= 1'b0;
    repeat (5) @(posedge hclk);
    wd_strap <= 2'h0;
    kick_en <= 1'b0;
    supply <= 1'b1;
    hold_len();
    chk_rng("restart hold", RL, RL + 6, len);
    cause_is(32'h0000_0001);
    quiet("wd disabled", 300);
    @(posedge hclk);
    lock_ok <= 1'b0;
    wait_pull();
    chk_rng("lockout wait", 0, 6, wt);
    @(posedge hclk);
    wd_strap <= 2'h2;
    lock_ok <= 1'b1;
    hold_len();
    hold_len();
    chk_rng("long wd wait", WL - 6, WL + 6, wt);
    @(posedge hclk);
    wd_strap <= 2'h3;
    supply <= 1'b0;
    wait_pull();
    @(posedge hclk);
    supply <= 1'b1;
    hold_len();
    hold_len();
    chk_rng("adj wd wait", WA - 6, WA + 6, wt);
    $display("done supply");
  endtask : t_supply

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    #80000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, supply, kick_en} = 4'h0;
    {btn_n, lock_ok} = 2'h3;
    {haddr, hwdata} = 64'h0000_0000_0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    wd_strap = 2'h1;
    rst_strap = 2'h1;
    kick_gap = 8'h28;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_power_up();
    t_expire();
    t_window();
    t_button();
    t_supply();
    report_and_stop();
  end
endmodule : tb
